// ### logic/mpr_pkg.sv
`default_nettype none
package mpr_pkg;
	// coprocessor register numbers (primary register field)
	localparam logic [3:0] CRN_BUF   = 4'h3;
	localparam logic [3:0] CRN_RSVD  = 4'h4;
	localparam logic [3:0] CRN_FSR   = 4'h5;
	localparam logic [3:0] CRN_FAR   = 4'h6;
	// secondary opcodes
	localparam logic [2:0] OP2_D_XL  = 3'h0;
	localparam logic [2:0] OP2_I_XL  = 3'h1;
	localparam logic [2:0] OP2_D_EXT = 3'h2;
	localparam logic [2:0] OP2_I_EXT = 3'h3;
	localparam logic [2:0] OP2_D_PU  = 3'h4;
	localparam logic [2:0] OP2_I_PU  = 3'h5;
	// fault status layout
	localparam int FS_EXT    = 10;
	localparam int FS_DOM_HI = 7;
	localparam int FS_DOM_LO = 4;
	// fault status codes
	localparam logic [3:0] ST_MISS   = 4'h0;
	localparam logic [3:0] ST_ALIGN  = 4'h1;
	localparam logic [3:0] ST_DEBUG  = 4'h2;
	localparam logic [3:0] ST_L1EA   = 4'hc;
	localparam logic [3:0] ST_L1TR   = 4'h5;
	localparam logic [3:0] ST_L2EA   = 4'he;
	localparam logic [3:0] ST_L2TR   = 4'h7;
	localparam logic [3:0] ST_SDOM   = 4'h9;
	localparam logic [3:0] ST_PDOM   = 4'hb;
	localparam logic [3:0] ST_SPERM  = 4'hd;
	localparam logic [3:0] ST_PPERM  = 4'hf;
	localparam logic [3:0] ST_NTEA   = 4'h8;
	localparam logic [3:0] ST_IMPR   = 4'h6;
	// fault request bit positions, highest priority first
	localparam int NFLT = 13;
	localparam int F_IMPR = 0;
	localparam int F_ALIGN = 1;
	localparam int F_MISS = 2;
	localparam int F_L1EA = 3;
	localparam int F_L1TR = 4;
	localparam int F_L2EA = 5;
	localparam int F_L2TR = 6;
	localparam int F_SDOM = 7;
	localparam int F_PDOM = 8;
	localparam int F_SPERM = 9;
	localparam int F_PPERM = 10;
	localparam int F_NTEA = 11;
	localparam int F_DEBUG = 12;
	// widths and reset values
	localparam int NREG = 8;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// address offsets for instruction fault address
	localparam logic [31:0] PC_OFS_WIDE = 32'h0000_0008;
	localparam logic [31:0] PC_OFS_NARROW = 32'h0000_0004;
	// decoded permission kinds
	typedef enum logic [2:0] {
		MPR_NONE, MPR_PRW, MPR_PRW_UR, MPR_FULL, MPR_PRO, MPR_RO, MPR_UNPRED
	} mpr_perm_e;
endpackage : mpr_pkg
`default_nettype wire

// ### logic/mpr_regs.sv
// Notes on behaviour
// - eight bufferable bits, reset zero
// - bufferable register only in protection mode
// - register 4 access raises undefined
// - status: ext bit10, region 7:4, type 3:0
// - highest priority simultaneous fault reported
// - miss code 0000, priority 2, both
// - walk codes valid translation mode only
// - access permission fault code 1101
// - page permission fault 1111, translation only
// - debug event code 0010, lowest priority
// - data/instruction status capture latest event
// - status opcodes 0/1 translation, 4/5 protection
// - extended permissions eight nibbles per side
// - extended permission code decode
// - standard permissions eight pairs, upper zero
// - standard permission code decode
// - standard write clears extended upper bits
// - permission registers protection mode only
// - data address captures faulting address
// - instruction address is pc plus 8/4
`timescale 1ns/1ns
`default_nettype none
module mpr_regs
	import mpr_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            nrst,
	// mode pin: 1 translation, 0 protection
	input  wire logic            translation_vs_protection_select,
	// coprocessor register transfer
	input  wire logic            cp_valid,
	input  wire logic            cp_write,
	input  wire logic [3:0]      cp_crn,
	input  wire logic [3:0]      cp_crm,
	input  wire logic [2:0]      cp_op2,
	input  wire logic [31:0]     cp_wdata,
	output logic                 cp_done,
	output logic                 cp_undef,
	output logic [31:0]          cp_rdata,
	// data abort or watchpoint taken
	input  wire logic            dabort_taken,
	input  wire logic [NFLT-1:0] dfault_req,
	input  wire logic [3:0]      dfault_region,
	input  wire logic [31:0]     dfault_mva,
	// prefetch abort or breakpoint taken
	input  wire logic            iabort_taken,
	input  wire logic [NFLT-1:0] ifault_req,
	input  wire logic [3:0]      ifault_region,
	input  wire logic [31:0]     ifault_pc,
	input  wire logic            ifault_narrow,
	// region attributes to the access checker
	output logic [7:0]           region_bufferable_flags,
	output logic [31:0]          data_region_permission_fields,
	output logic [31:0]          instr_region_permission_fields
);

	typedef struct packed {
		logic        done;
		logic        undef;
		logic [31:0] rdata;
		logic [7:0]  buf_bits;
		logic [10:0] dfs;
		logic [10:0] ifs;
		logic [31:0] dext;
		logic [31:0] iext;
		logic [31:0] dfa;
		logic [31:0] ifa;
	} mpr_state_s;

	mpr_state_s s_q, s_d;

	////////////////////////////////////////////////////////////////////////////
	// fault prioritising: lowest index wins

	// fault kinds without meaning in protection mode are dropped up front, so an
	// event made only of them leaves status and address untouched
	function automatic logic [NFLT-1:0] mask_req(input logic [NFLT-1:0] req, input logic xl_mode);
		logic [NFLT-1:0] r;
		r = req;
		if (!xl_mode) begin
			r[F_L1EA] = 1'b0;
			r[F_L1TR] = 1'b0;
			r[F_L2EA] = 1'b0;
			r[F_L2TR] = 1'b0;
			r[F_SDOM] = 1'b0;
			r[F_PDOM] = 1'b0;
			r[F_PPERM] = 1'b0;
		end
		return r;
	endfunction : mask_req

	function automatic logic [10:0] fault_code(input logic [NFLT-1:0] req,
		input logic xl, input logic [3:0] region);
		logic [10:0] c;
		logic [NFLT-1:0] r;
		c = '0;
		r = mask_req(req, xl);
		c[FS_DOM_HI:FS_DOM_LO] = region;
		// scan from lowest priority up so the highest one lands last
		for (int k = NFLT - 1; k >= 0; k--) begin
			if (r[k]) begin
				c[FS_EXT] = (k == F_IMPR);
				case (k)
					F_IMPR:  c[3:0] = ST_IMPR;
					F_ALIGN: c[3:0] = ST_ALIGN;
					F_MISS:  c[3:0] = ST_MISS;
					F_L1EA:  c[3:0] = ST_L1EA;
					F_L1TR:  c[3:0] = ST_L1TR;
					F_L2EA:  c[3:0] = ST_L2EA;
					F_L2TR:  c[3:0] = ST_L2TR;
					F_SDOM:  c[3:0] = ST_SDOM;
					F_PDOM:  c[3:0] = ST_PDOM;
					F_SPERM: c[3:0] = ST_SPERM;
					F_PPERM: c[3:0] = ST_PPERM;
					F_NTEA:  c[3:0] = ST_NTEA;
					default: c[3:0] = ST_DEBUG;
				endcase
			end
		end
		return c;
	endfunction : fault_code

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic xl;
	logic hit_buf, hit_dfs, hit_ifs, hit_dext, hit_iext, hit_dstd, hit_istd;
	logic hit_dfa, hit_ifa, legal;
	logic [31:0] dstd_view, istd_view;
	logic d_any, i_any;

	assign xl = translation_vs_protection_select;
	assign d_any = dabort_taken && (mask_req(dfault_req, xl) != '0);
	assign i_any = iabort_taken && (mask_req(ifault_req, xl) != '0) && !ifault_req[F_ALIGN];

	// standard view: low two bits of each nibble, packed
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_std
			assign dstd_view[2*g +: 2] = s_q.dext[4*g +: 2];
			assign istd_view[2*g +: 2] = s_q.iext[4*g +: 2];
		end
	endgenerate
	assign dstd_view[31:16] = '0;
	assign istd_view[31:16] = '0;

	// permission decode per region, kept beside the raw fields so the checks can
	// hold the two encodings against each other; the access checker decodes again
	function automatic mpr_perm_e perm_ext(input logic [3:0] code);
		mpr_perm_e p;
		case (code)
			4'h0:    p = MPR_NONE;
			4'h1:    p = MPR_PRW;
			4'h2:    p = MPR_PRW_UR;
			4'h3:    p = MPR_FULL;
			4'h5:    p = MPR_PRO;
			4'h6:    p = MPR_RO;
			default: p = MPR_UNPRED; // no defined access for the remaining codes
		endcase
		return p;
	endfunction : perm_ext

	function automatic mpr_perm_e perm_std(input logic [1:0] code);
		mpr_perm_e p;
		case (code)
			2'h0:    p = MPR_NONE;
			2'h1:    p = MPR_PRW;
			2'h2:    p = MPR_PRW_UR;
			default: p = MPR_FULL;
		endcase
		return p;
	endfunction : perm_std

	mpr_perm_e dperm_ext [NREG];
	mpr_perm_e iperm_ext [NREG];
	mpr_perm_e dperm_std [NREG];
	mpr_perm_e iperm_std [NREG];

	genvar h;
	generate
		for (h = 0; h < NREG; h++) begin : g_dec
			assign dperm_ext[h] = perm_ext(s_q.dext[4*h +: 4]);
			assign iperm_ext[h] = perm_ext(s_q.iext[4*h +: 4]);
			assign dperm_std[h] = perm_std(dstd_view[2*h +: 2]);
			assign iperm_std[h] = perm_std(istd_view[2*h +: 2]);
			// both views share storage, so with the upper pair clear they must agree
			dview_agree_a: assert property (@(posedge clk) disable iff (!nrst)
				s_q.dext[4*h+2 +: 2] == 2'b00 |-> dperm_ext[h] == dperm_std[h])
				else $error("data permission views disagree");
			iview_agree_a: assert property (@(posedge clk) disable iff (!nrst)
				s_q.iext[4*h+2 +: 2] == 2'b00 |-> iperm_ext[h] == iperm_std[h])
				else $error("instruction permission views disagree");
			// a set top bit never grants a defined access
			dext_unpred_a: assert property (@(posedge clk) disable iff (!nrst)
				s_q.dext[4*h+3] |-> dperm_ext[h] == MPR_UNPRED)
				else $error("data extended code decoded as access");
			iext_unpred_a: assert property (@(posedge clk) disable iff (!nrst)
				s_q.iext[4*h+3] |-> iperm_ext[h] == MPR_UNPRED)
				else $error("instruction extended code decoded as access");
		end
	endgenerate

	always_comb begin
		hit_buf  = cp_crn == CRN_BUF && !xl && cp_op2 == OP2_D_XL;
		hit_dfs  = cp_crn == CRN_FSR && (xl ? cp_op2 == OP2_D_XL : cp_op2 == OP2_D_PU);
		hit_ifs  = cp_crn == CRN_FSR && (xl ? cp_op2 == OP2_I_XL : cp_op2 == OP2_I_PU);
		hit_dext = cp_crn == CRN_FSR && !xl && cp_op2 == OP2_D_EXT;
		hit_iext = cp_crn == CRN_FSR && !xl && cp_op2 == OP2_I_EXT;
		hit_dstd = cp_crn == CRN_FSR && !xl && cp_op2 == OP2_D_XL;
		hit_istd = cp_crn == CRN_FSR && !xl && cp_op2 == OP2_I_XL;
		hit_dfa  = cp_crn == CRN_FAR && cp_op2 == (xl ? OP2_D_XL : OP2_D_PU);
		hit_ifa  = cp_crn == CRN_FAR && cp_op2 == (xl ? OP2_I_XL : OP2_I_PU);
		// register 4 never matches anything, so it always traps
		legal = cp_crm == 4'h0 && cp_crn != CRN_RSVD && (hit_buf || hit_dfs || hit_ifs
			|| hit_dext || hit_iext || hit_dstd || hit_istd || hit_dfa || hit_ifa);

		s_d = s_q;
		s_d.done = cp_valid && legal;
		s_d.undef = cp_valid && !legal;
		s_d.rdata = ZERO32;

		// reads: unused upper bits return zero
		if (cp_valid && legal && !cp_write) begin
			if (hit_buf)  s_d.rdata = {24'h000000, s_q.buf_bits};
			if (hit_dfs)  s_d.rdata = {21'h000000, s_q.dfs & 11'h4ff};
			if (hit_ifs)  s_d.rdata = {21'h000000, s_q.ifs & 11'h4ff};
			if (hit_dext) s_d.rdata = s_q.dext;
			if (hit_iext) s_d.rdata = s_q.iext;
			if (hit_dstd) s_d.rdata = dstd_view;
			if (hit_istd) s_d.rdata = istd_view;
			if (hit_dfa)  s_d.rdata = s_q.dfa;
			if (hit_ifa)  s_d.rdata = s_q.ifa;
		end

		// writes; the restore path loads bits 10 and 7:0 of the word, with reserved status bits 9:8 cleared
		if (cp_valid && legal && cp_write) begin
			if (hit_buf)  s_d.buf_bits = cp_wdata[7:0];
			if (hit_dfs)  s_d.dfs = cp_wdata[10:0] & 11'h4ff;
			if (hit_ifs)  s_d.ifs = cp_wdata[10:0] & 11'h4ff;
			if (hit_dext) s_d.dext = cp_wdata;
			if (hit_iext) s_d.iext = cp_wdata;
			for (int k = 0; k < NREG; k++) begin
				if (hit_dstd) s_d.dext[4*k +: 4] = {2'b00, cp_wdata[2*k +: 2]};
				if (hit_istd) s_d.iext[4*k +: 4] = {2'b00, cp_wdata[2*k +: 2]};
			end
			if (hit_dfa)  s_d.dfa = cp_wdata;
			if (hit_ifa)  s_d.ifa = cp_wdata;
		end

		// taken events win over a write in the same cycle
		if (d_any) begin
			s_d.dfs = fault_code(dfault_req, xl, dfault_region);
			s_d.dfa = dfault_mva;
		end
		if (i_any) begin
			s_d.ifs = fault_code(ifault_req, xl, ifault_region);
			s_d.ifa = ifault_pc + (ifault_narrow ? PC_OFS_NARROW : PC_OFS_WIDE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; permissions and fault words reset to zero for determinism

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.buf_bits <= BUF_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cp_done = s_q.done;
	assign cp_undef = s_q.undef;
	assign cp_rdata = s_q.rdata;
	assign region_bufferable_flags = s_q.buf_bits;
	assign data_region_permission_fields = s_q.dext; // decoded downstream
	assign instr_region_permission_fields = s_q.iext;

	////////////////////////////////////////////////////////////////////////////
	// checks

	rsvd_trap_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_crn == CRN_RSVD |=> cp_undef && !cp_done)
		else $error("register 4 access did not trap");
	buf_mode_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_crn == CRN_BUF && xl |=> cp_undef)
		else $error("bufferable access in translation mode");
	buf_write_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_write && cp_crn == CRN_BUF && cp_crm == 4'h0 && !xl
		&& cp_op2 == OP2_D_XL |=> region_bufferable_flags == $past(cp_wdata[7:0]))
		else $error("bufferable write lost");
	miss_code_a: assert property (@(posedge clk) disable iff (!nrst)
		dabort_taken && dfault_req[F_MISS] && !dfault_req[F_IMPR] && !dfault_req[F_ALIGN]
		|=> s_q.dfs[3:0] == ST_MISS && !s_q.dfs[FS_EXT])
		else $error("miss code wrong");
	perm_prio_a: assert property (@(posedge clk) disable iff (!nrst)
		dabort_taken && !xl && dfault_req[F_SPERM] && dfault_req[F_DEBUG]
		&& dfault_req[2:0] == 3'h0 |=> s_q.dfs[3:0] == ST_SPERM)
		else $error("permission fault priority wrong");
	debug_code_a: assert property (@(posedge clk) disable iff (!nrst)
		iabort_taken && ifault_req == 13'h1000 |=> s_q.ifs[3:0] == ST_DEBUG)
		else $error("debug code wrong");
	ifa_pc_a: assert property (@(posedge clk) disable iff (!nrst)
		i_any |=> s_q.ifa == $past(ifault_pc)
		+ ($past(ifault_narrow) ? PC_OFS_NARROW : PC_OFS_WIDE))
		else $error("instruction address offset wrong");
	std_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_write && hit_dstd && cp_crm == 4'h0 |=> (s_q.dext & 32'hcccccccc) == 0)
		else $error("standard write kept upper bits");
	hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!dabort_taken && !(cp_valid && cp_write && cp_crn == CRN_FSR) |=> $stable(s_q.dfs))
		else $error("data status changed without cause");

	////////////////////////////////////////////////////////////////////////////
	// checks on the transfer answer and on event capture

	// only the first secondary register number is decoded
	crm_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_crm != 4'h0 |=> cp_undef && !cp_done)
		else $error("nonzero secondary register accepted");
	// a transfer answers one way only
	answer_one_a: assert property (@(posedge clk) disable iff (!nrst)
		!(cp_done && cp_undef))
		else $error("done and undefined together");
	// read data is zero outside a completed transfer
	rdata_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		!cp_done |-> cp_rdata == ZERO32)
		else $error("read data not zero when idle");
	// reserved status bits never hold a one
	fs_reserved_a: assert property (@(posedge clk) disable iff (!nrst)
		(s_q.dfs & 11'h300) == 11'h000 && (s_q.ifs & 11'h300) == 11'h000)
		else $error("reserved status bits set");
	// translation-only faults alone leave protection-mode records alone
	prot_ignore_a: assert property (@(posedge clk) disable iff (!nrst)
		dabort_taken && !xl && mask_req(dfault_req, xl) == '0 && !cp_valid
		|=> $stable(s_q.dfs) && $stable(s_q.dfa))
		else $error("invalid fault kind recorded");
	dfa_capture_a: assert property (@(posedge clk) disable iff (!nrst)
		d_any |=> s_q.dfa == $past(dfault_mva))
		else $error("data fault address not captured");
	dregion_a: assert property (@(posedge clk) disable iff (!nrst)
		d_any |=> s_q.dfs[FS_DOM_HI:FS_DOM_LO] == $past(dfault_region))
		else $error("data fault region not captured");
	iregion_a: assert property (@(posedge clk) disable iff (!nrst)
		i_any |=> s_q.ifs[FS_DOM_HI:FS_DOM_LO] == $past(ifault_region))
		else $error("instruction fault region not captured");
	// alignment is a data-side fault only
	ifs_align_a: assert property (@(posedge clk) disable iff (!nrst)
		iabort_taken && ifault_req[F_ALIGN] && !cp_valid |=> $stable(s_q.ifs) && $stable(s_q.ifa))
		else $error("alignment fault reached instruction side");
	impr_ext_a: assert property (@(posedge clk) disable iff (!nrst)
		dabort_taken && dfault_req[F_IMPR] |=> s_q.dfs[FS_EXT] && s_q.dfs[3:0] == ST_IMPR)
		else $error("imprecise abort not reported first");
	ddebug_a: assert property (@(posedge clk) disable iff (!nrst)
		dabort_taken && dfault_req == (NFLT'(1) << F_DEBUG) |=> s_q.dfs[3:0] == ST_DEBUG)
		else $error("watchpoint code wrong");
	std_read_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && !cp_write && hit_dstd && cp_crm == 4'h0
		|=> cp_done && cp_rdata[31:16] == 16'h0000)
		else $error("standard view upper half not zero");
	ext_write_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && cp_write && hit_dext && cp_crm == 4'h0 |=> s_q.dext == $past(cp_wdata))
		else $error("extended permission write lost");
	fs_mode_a: assert property (@(posedge clk) disable iff (!nrst)
		cp_valid && xl && cp_crn == CRN_FSR && cp_op2 == OP2_D_PU |=> cp_undef)
		else $error("protection status opcode accepted in translation mode");

endmodule : mpr_regs
`default_nettype wire

// ### testbench/mpr_core_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// core side: issues one coprocessor transfer at a time
module mpr_core_model (
	// clock
	input  wire logic        clk,
	// transfer request
	output logic             cp_valid,
	output logic             cp_write,
	output logic [3:0]       cp_crn,
	output logic [3:0]       cp_crm,
	output logic [2:0]       cp_op2,
	output logic [31:0]      cp_wdata,
	// answer
	input  wire logic        cp_done,
	input  wire logic        cp_undef,
	input  wire logic [31:0] cp_rdata
);
	// secondary register number used by the next transfers
	logic [3:0] crm_sel = 4'h0;
	initial begin
		{cp_valid, cp_write, cp_crn, cp_crm, cp_op2, cp_wdata} = '0;
	end
	// request held one cycle, answer sampled once the taking edge has landed
	task automatic xfer(input logic w, input logic [3:0] crn, input logic [2:0] op2,
		input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] ans);
		@(posedge clk);
		cp_valid <= 1'b1;
		cp_write <= w;
		cp_crn <= crn;
		cp_crm <= crm_sel;
		cp_op2 <= op2;
		cp_wdata <= wd;
		@(posedge clk);
		// released lines flip so a stale value can never pass for a live one
		cp_valid <= 1'b0;
		cp_write <= ~w;
		cp_crn <= ~crn;
		cp_crm <= ~crm_sel;
		cp_op2 <= ~op2;
		cp_wdata <= ~wd;
		#1;
		rd = cp_rdata;
		ans = {cp_done, cp_undef};
	endtask : xfer
endmodule : mpr_core_model
`default_nettype wire

// ### testbench/mpr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mpr_regs_tb;
	import mpr_pkg::*;
	logic            clk = 1'b0;
	logic            nrst = 1'b0;
	logic            xl = 1'b0;
	logic            cp_valid, cp_write, cp_done, cp_undef;
	logic [3:0]      cp_crn, cp_crm;
	logic [2:0]      cp_op2;
	logic [31:0]     cp_wdata, cp_rdata, rd, dperm, iperm;
	logic [7:0]      bflags;
	logic [1:0]      ans;
	logic            dtk = 1'b0, itk = 1'b0, nar = 1'b0;
	logic [NFLT-1:0] freq = '0;
	logic [3:0]      freg = '0;
	logic [31:0]     fadr = '0;
	int              fail_count = 0;
	int              checked = 0;
	int              fi [11] = '{F_MISS, F_L1EA, F_L1TR, F_L2EA, F_L2TR, F_SDOM, F_PDOM, F_SPERM,
		F_PPERM, F_NTEA, F_DEBUG};
	logic [3:0]      fc [11] = '{ST_MISS, ST_L1EA, ST_L1TR, ST_L2EA, ST_L2TR, ST_SDOM, ST_PDOM,
		ST_SPERM, ST_PPERM, ST_NTEA, ST_DEBUG};

	always #5 clk = ~clk;

	mpr_regs dut_u (.clk(clk), .nrst(nrst), .translation_vs_protection_select(xl),
		.cp_valid(cp_valid), .cp_write(cp_write), .cp_crn(cp_crn), .cp_crm(cp_crm),
		.cp_op2(cp_op2), .cp_wdata(cp_wdata), .cp_done(cp_done), .cp_undef(cp_undef),
		.cp_rdata(cp_rdata), .dabort_taken(dtk), .dfault_req(freq), .dfault_region(freg),
		.dfault_mva(fadr), .iabort_taken(itk), .ifault_req(freq), .ifault_region(freg),
		.ifault_pc(fadr), .ifault_narrow(nar), .region_bufferable_flags(bflags),
		.data_region_permission_fields(dperm), .instr_region_permission_fields(iperm));
	mpr_core_model core_u (.clk(clk), .cp_valid(cp_valid), .cp_write(cp_write),
		.cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata),
		.cp_done(cp_done), .cp_undef(cp_undef), .cp_rdata(cp_rdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude;
		if (fail_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	// accepted transfers answer done, refused ones answer undef with zero data
	task automatic wr(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] wd);
		core_u.xfer(1'b1, crn, op2, wd, rd, ans);
		chk({30'h0, ans}, 32'h2);
	endtask : wr
	task automatic rdx(input logic [3:0] crn, input logic [2:0] op2, input logic [31:0] exp);
		core_u.xfer(1'b0, crn, op2, 32'h0, rd, ans);
		chk({30'h0, ans}, 32'h2);
		chk(rd, exp);
	endtask : rdx
	task automatic undef(input logic [3:0] crn, input logic [2:0] op2);
		core_u.xfer(1'b0, crn, op2, 32'h0, rd, ans);
		chk({30'h0, ans}, 32'h1);
		chk(rd, 32'h0);
	endtask : undef
	// both sides see the same request; only the selected side is taken
	task automatic flt(input logic d, input logic i, input logic [NFLT-1:0] req,
		input logic [3:0] r, input logic [31:0] a, input logic n);
		@(posedge clk);
		{dtk, itk, freq, freg, fadr, nar} <= {d, i, req, r, a, n};
		@(posedge clk);
		{dtk, itk, freq} <= '0;
	endtask : flt
	function automatic logic [NFLT-1:0] b(input int k);
		return NFLT'(1) << k;
	endfunction : b
	function automatic logic [31:0] fs(input logic e, input logic [3:0] r, input logic [3:0] c);
		return {21'h0, e, 2'h0, r, c};
	endfunction : fs

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rdx(CRN_BUF, 3'h0, 32'h0);
		chk({24'h0, bflags}, 32'h0);
		wr(CRN_BUF, 3'h0, 32'h0000_00a5);
		chk({24'h0, bflags}, 32'ha5);
		undef(CRN_RSVD, 3'h0);
		// permissions programmed before any use of the regions
		for (int s = 0; s < 2; s++) begin
			wr(CRN_FSR, OP2_D_EXT | 3'(s), 32'hf654_3210);
			rdx(CRN_FSR, OP2_D_EXT | 3'(s), 32'hf654_3210);
			chk(s ? iperm : dperm, 32'hf654_3210);
			wr(CRN_FSR, 3'(s), 32'habcd_1b6e);
			rdx(CRN_FSR, 3'(s), 32'h0000_1b6e);
			rdx(CRN_FSR, OP2_D_EXT | 3'(s), 32'h0123_1232);
		end
		@(posedge clk);
		xl <= 1'b1;
		undef(CRN_BUF, 3'h0);
		undef(CRN_FSR, OP2_D_EXT);
		undef(CRN_FSR, OP2_I_EXT);
		undef(CRN_RSVD, 3'h1);
		undef(CRN_FSR, OP2_D_PU);
		// each code from miss to debug alone with a debug request beside it, both sides
		for (int k = 0; k < 11; k++) begin
			flt(1'b1, 1'b0, b(fi[k]) | b(F_DEBUG), 4'(k), 32'h100 * k, 1'b0);
			rdx(CRN_FSR, OP2_D_XL, fs(1'b0, 4'(k), fc[k]));
			rdx(CRN_FAR, OP2_D_XL, 32'h100 * k);
			flt(1'b0, 1'b1, b(fi[k]) | b(F_DEBUG), 4'(k + 8), 32'h40 * k, k[0]);
			rdx(CRN_FSR, OP2_I_XL, fs(1'b0, 4'(k + 8), fc[k]));
			rdx(CRN_FAR, OP2_I_XL, 32'h40 * k + (k[0] ? PC_OFS_NARROW : PC_OFS_WIDE));
		end
		flt(1'b1, 1'b0, b(F_IMPR) | b(F_MISS), 4'h3, 32'h0, 1'b0);
		rdx(CRN_FSR, OP2_D_XL, fs(1'b1, 4'h3, ST_IMPR));
		rdx(CRN_FSR, OP2_I_XL, fs(1'b0, 4'h2, ST_DEBUG));
		flt(1'b0, 1'b0, b(F_MISS), 4'h1, 32'h0, 1'b0);
		rdx(CRN_FSR, OP2_D_XL, fs(1'b1, 4'h3, ST_IMPR));
		// alignment outranks a miss and stays on the data side
		flt(1'b1, 1'b1, b(F_ALIGN) | b(F_MISS), 4'h4, 32'h77, 1'b0);
		rdx(CRN_FSR, OP2_D_XL, fs(1'b0, 4'h4, ST_ALIGN));
		rdx(CRN_FAR, OP2_D_XL, 32'h77);
		rdx(CRN_FSR, OP2_I_XL, fs(1'b0, 4'h2, ST_DEBUG));
		rdx(CRN_FAR, OP2_I_XL, 32'h288);
		@(posedge clk);
		xl <= 1'b0;
		rdx(CRN_BUF, 3'h0, 32'ha5);
		flt(1'b1, 1'b0, b(F_SPERM) | b(F_NTEA) | b(F_DEBUG), 4'h6, 32'h0, 1'b0);
		rdx(CRN_FSR, OP2_D_PU, fs(1'b0, 4'h6, ST_SPERM));
		flt(1'b0, 1'b1, b(F_MISS) | b(F_SPERM), 4'h5, 32'h0, 1'b0);
		rdx(CRN_FSR, OP2_I_PU, fs(1'b0, 4'h5, ST_MISS));
		// restore by read-modify-write of the region field only
		rdx(CRN_FSR, OP2_D_PU, fs(1'b0, 4'h6, ST_SPERM));
		wr(CRN_FSR, OP2_D_PU, {rd[31:8], 4'h2, rd[3:0]});
		rdx(CRN_FSR, OP2_D_PU, fs(1'b0, 4'h2, ST_SPERM));
		// a walk abort has no meaning here and must leave the record alone
		flt(1'b1, 1'b0, b(F_L1EA), 4'h9, 32'h1234, 1'b0);
		rdx(CRN_FSR, OP2_D_PU, fs(1'b0, 4'h2, ST_SPERM));
		undef(CRN_BUF, 3'h1);
		core_u.crm_sel = 4'h1;
		undef(CRN_BUF, 3'h0);
		core_u.crm_sel = 4'h0;
		wr(CRN_FAR, OP2_D_PU, 32'hdead_0004);
		rdx(CRN_FAR, OP2_D_PU, 32'hdead_0004);
		conclude();
	end
endmodule : mpr_regs_tb
`default_nettype wire
